// *** dv/dbc_channel_sva.sv ***
// Port checks for the byte channel.
`timescale 1ns/1ps
module dbc_channel_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic cpu_stall_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic in_ready_o,
  input wire logic out_valid_o,
  input wire logic [7:0] out_data_o,
  input wire logic out_ready_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_take_to_busy: assert property (cmd_valid_i && cmd_ready_o && !busy_o |-> ##2 busy_o)
    else $error("busy did not follow an accepted command");
  a_ready_after_reset: assert property ($fell(rst_i) |=> cmd_ready_o)
    else $error("command ready missing after reset");
  a_setup_cycle: assert property ($rose(busy_o) |-> ##25 (mem_req_o || in_ready_o))
    else $error("first memory cycle not after one setup cycle");
  a_read_to_out: assert property (mem_req_o && !mem_we_o |-> ##25 out_valid_o)
    else $error("output byte not offered one memory cycle after read");
  a_req_spacing: assert property (mem_req_o |=> !mem_req_o [*8])
    else $error("memory cycles closer than allowed");
  a_write_in_cycle: assert property (mem_we_o |-> mem_req_o)
    else $error("write strobe outside a memory cycle");
  a_out_held: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("output byte dropped before acceptance");
  a_stall_in_run: assert property (cpu_stall_o |-> busy_o)
    else $error("processor stalled with no transfer");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_stall_ends: assert property (done_o |-> !cpu_stall_o && !busy_o)
    else $error("stall or busy left set after done");
  c_stalled_done: cover property (done_o && $fell(cpu_stall_o));
  c_input_write: cover property (mem_we_o);
  c_out_stall: cover property (out_valid_o && !out_ready_i);
endmodule : dbc_channel_sva
bind dbc_channel dbc_channel_sva dbc_channel_sva_i (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cmd_valid_i(cmd_valid_i),
  .cmd_ready_o(cmd_ready_o),
  .cpu_stall_o(cpu_stall_o),
  .busy_o(busy_o),
  .done_o(done_o),
  .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o),
  .in_ready_o(in_ready_o),
  .out_valid_o(out_valid_o),
  .out_data_o(out_data_o),
  .out_ready_i(out_ready_i)
);

// *** dv/dbc_channel_tb.sv ***
// Self-checking bench for the byte channel.
`timescale 1ns/1ps
module dbc_channel_tb;
  typedef struct packed {
    logic ov, som, slow;
    logic [15:0] addr, cnt, n;
  } dbc_row_type;
  logic clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, slow = 1'b0;
  dbc_pkg::dbc_cmd_type cmd_i = '0;
  logic cmd_ready_o, cpu_stall_o, busy_o, done_o, mem_req_o, mem_we_o, out_valid_o, out_ready_i, in_valid_i, in_ready_o;
  logic [15:0] mem_addr_o;
  logic [7:0] mem_wdata_o, out_data_o, in_data_i;
  dbc_pkg::dbc_mem_byte_type mem [256], mem_rdata_i;
  int err_count = 0, samples_checked = 0, cyc = 0, reqs = 0, stalls = 0, r0, s0, q0, t0;
  dbc_row_type rows [4] = '{'{1'b0, 1'b0, 1'b0, 16'h0007, 16'h0000, 16'h0001},
    '{1'b1, 1'b0, 1'b0, 16'h0010, 16'h0005, 16'h0005}, '{1'b1, 1'b1, 1'b0, 16'h0011, 16'h0009, 16'h0003},
    '{1'b0, 1'b0, 1'b1, 16'h000b, 16'h0002, 16'h0002}};
  assign mem_rdata_i = mem[mem_addr_o[7:0]];
  dbc_channel dbc_channel_i (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o), .cpu_stall_o(cpu_stall_o), .busy_o(busy_o), .done_o(done_o), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
    .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i), .in_valid_i(in_valid_i),
    .in_data_i(in_data_i), .in_ready_o(in_ready_o));
  dbc_periph_model dbc_periph_model_i (.clk_i(clk_i), .slow_i(slow), .out_valid_i(out_valid_o),
    .out_data_i(out_data_o), .out_ready_o(out_ready_i), .in_ready_i(in_ready_o), .in_valid_o(in_valid_i),
    .in_data_o(in_data_i));
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    reqs <= reqs + int'(mem_req_o);
    stalls <= stalls + int'(cpu_stall_o);
    if (mem_req_o && mem_we_o) mem[mem_addr_o[7:0]].data <= mem_wdata_o;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic send(input logic dir, ov, som, input logic [15:0] a, c);
    for (int k = 0; k < 500 && cmd_ready_o !== 1'b1; k++) @(negedge clk_i);
    cmd_i = '{dir, ov, som, a, c};
    cmd_valid_i = 1'b1;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
  endtask : send
  task automatic wait_done();
    for (int k = 0; k < 5000 && done_o !== 1'b1; k++) @(negedge clk_i);
    @(negedge clk_i);
  endtask : wait_done
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = '{i == 8'h13 || i == 8'h31, 8'(i) ^ 8'h5a};
    repeat (10) @(negedge clk_i);
    check("reset_outs", 16'h0, {9'h0, cmd_ready_o, busy_o, done_o, mem_req_o, out_valid_o, in_ready_o, cpu_stall_o});
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check("ready", 16'h1, {15'h0, cmd_ready_o});
    $display("test reset done");
    foreach (rows[r]) begin
      r0 = reqs;
      s0 = stalls;
      t0 = cyc;
      q0 = dbc_periph_model_i.rx_q.size();
      slow = rows[r].slow;
      send(1'b1, rows[r].ov, rows[r].som, rows[r].addr, rows[r].cnt);
      wait_done();
      check("out_count", rows[r].n, 16'(dbc_periph_model_i.rx_q.size() - q0));
      check("mem_cycles", rows[r].n, 16'(reqs - r0));
      check("out_time", 16'h1, {15'h0, (cyc - t0) >= dbc_pkg::MEM_CYCLE_CLKS * (rows[r].n + 1)});
      check("stall", {15'h0, !rows[r].ov}, {15'h0, stalls > s0});
      for (int b = 0; b < rows[r].n; b++)
        check("out_data", {8'h0, (rows[r].addr[7:0] + 8'(b)) ^ 8'h5a}, {8'h0, dbc_periph_model_i.rx_q[q0 + b]});
      $display("test row %0d done", r);
    end
    q0 = dbc_periph_model_i.rx_q.size();
    send(1'b1, 1'b1, 1'b0, 16'h0020, 16'h0001);
    send(1'b1, 1'b1, 1'b0, 16'h0040, 16'h0000);
    check("held_ready", 16'h0, {15'h0, cmd_ready_o});
    wait_done();
    wait_done();
    check("b2b_count", 16'h2, 16'(dbc_periph_model_i.rx_q.size() - q0));
    $display("test back to back done");
    r0 = reqs;
    t0 = cyc;
    send(1'b0, 1'b0, 1'b1, 16'h002f, 16'h0009);
    wait_done();
    check("in_cycles", 16'h3, 16'(reqs - r0));
    check("in_time", 16'h1, {15'h0, (cyc - t0) >= dbc_pkg::MEM_CYCLE_CLKS + 3 * dbc_pkg::IN_BYTE_CLKS});
    for (int b = 0; b < 3; b++) begin
      check("in_data", {8'h0, 8'ha0 + 8'(b)}, {8'h0, mem[8'h2f + b].data});
      check("in_mark", {15'h0, b == 2}, {15'h0, mem[8'h2f + b].mark});
    end
    $display("test input done");
    report_and_stop();
  end
endmodule : dbc_channel_tb

// *** dv/dbc_periph_model.sv ***
// Peripheral model: byte sink for output and byte source for input.
`timescale 1ns/1ps
module dbc_periph_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic out_valid_i,
  input wire logic [7:0] out_data_i,
  output logic out_ready_o = 1'b0,
  input wire logic in_ready_i,
  output logic in_valid_o = 1'b0,
  output logic [7:0] in_data_o = 8'h00
);
  logic [7:0] rx_q [$];
  logic [7:0] tx_n = 8'h00;
  int gap = 0;
  always @(posedge clk_i) begin
    if (out_valid_i && out_ready_o) rx_q.push_back(out_data_i);
    out_ready_o <= slow_i ? ~out_ready_o : 1'b1;
    if (in_valid_o && !in_ready_i) begin
      in_valid_o <= 1'b0;
      in_data_o <= ~in_data_o;
      tx_n <= tx_n + 8'h01;
      gap <= 0;
    end else if (in_ready_i && !in_valid_o) begin
      gap <= gap + 1;
      if (gap == 0) in_data_o <= 8'ha0 + tx_n;
      if (gap == (slow_i ? 12 : 4)) in_valid_o <= 1'b1;
    end
  end
endmodule : dbc_periph_model

// *** verilog/dbc_channel.sv ***
// Buffered byte channel between core memory and one peripheral.
`timescale 1ns/1ps
// Summary of operation
// - Command bit picks overlapped run or processor stall until transfer ends.
// - Transfer is one byte or a block of up to 65535 bytes.
// - Transfer starts at any byte address, no alignment needed.
// - Block may end at a byte carrying a word mark.
// - Output: one setup memory cycle, then one memory cycle per byte.
// - Input: one setup memory cycle, then 1.33 us per stored byte.
// - Input writes leave destination word marks unchanged.
// - Hardware byte buffer sits between peripheral and memory.
// - Output sustains up to one byte per memory cycle.
// - Each memory byte holds eight data bits and a word-mark bit.
// - Each channel memory cycle lasts 980 ns.
module dbc_channel #(
  parameter int ADDR_W = dbc_pkg::ADDR_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire dbc_pkg::dbc_cmd_type cmd_i,
  output logic cmd_ready_o,
  output logic cpu_stall_o,
  output logic busy_o,
  output logic done_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire dbc_pkg::dbc_mem_byte_type mem_rdata_i,
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  input wire logic out_ready_i,
  input wire logic in_valid_i,
  input wire logic [7:0] in_data_i,
  output logic in_ready_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dbc_pkg::dbc_state_type state;
  dbc_pkg::dbc_cmd_type cur;
  dbc_pkg::dbc_cmd_type held;
  logic held_valid;
  logic [dbc_pkg::CNT_W-1:0] tmr;
  logic [dbc_pkg::LEN_W-1:0] remain;
  logic buf_mark;
  logic [1:0] in_valid_sync;
  logic [15:0] in_data_s1;
  logic [7:0] in_data_s2;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire tmr_done = (tmr == dbc_pkg::CNT_ONE);
  wire take_new = cmd_valid_i && cmd_ready_o;
  wire start_cmd = (state == dbc_pkg::ST_IDLE) && held_valid;
  wire count_end = (remain == dbc_pkg::LEN_W'(1));
  // A set mark ends the block only when the command asks for it.
  wire mark_end = cur.stop_on_mark && buf_mark;
  wire last_byte = count_end || mark_end;
  wire in_arrive = in_valid_sync[1] && in_ready_o;
  wire [ADDR_W-1:0] next_addr = mem_addr_o + ADDR_W'(1);

  // ---------------------------------------------------------------
  // Command holding register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_valid <= 1'b0;
      held <= '0;
      cmd_ready_o <= 1'b0;
    end else begin
      if (take_new) begin
        held <= cmd_i;
        held_valid <= 1'b1;
      end else if (start_cmd) begin
        held_valid <= 1'b0;
      end
      // Ready drops on the edge that fills the holder, so a second offer cannot overwrite it.
      cmd_ready_o <= !held_valid && !take_new;
    end
  end

  // ---------------------------------------------------------------
  // Peripheral input synchroniser
  // ---------------------------------------------------------------
  // The data bytes pass one stage more than the valid bit, so they have settled when valid is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_valid_sync <= 2'h0;
      in_data_s1 <= 16'h0000;
      in_data_s2 <= 8'h00;
    end else begin
      in_valid_sync <= {in_valid_sync[0], in_valid_i};
      in_data_s1 <= {in_data_s1[7:0], in_data_i};
      in_data_s2 <= in_data_s1[15:8];
    end
  end

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= dbc_pkg::ST_IDLE;
      cur <= '0;
      tmr <= dbc_pkg::CNT_ZERO;
      remain <= '0;
      buf_mark <= 1'b0;
      busy_o <= 1'b0;
      cpu_stall_o <= 1'b0;
      done_o <= 1'b0;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wdata_o <= 8'h00;
      out_valid_o <= 1'b0;
      out_data_o <= 8'h00;
      in_ready_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      // The timer runs down to zero; one marks the last clock of the present memory cycle.
      if (tmr != dbc_pkg::CNT_ZERO) begin
        tmr <= tmr - dbc_pkg::CNT_ONE;
      end
      case (state)
        dbc_pkg::ST_IDLE: begin
          if (start_cmd) begin
            cur <= held;
            mem_addr_o <= held.start_addr[ADDR_W-1:0];
            // A count of zero moves a single byte.
            remain <= (held.byte_count == '0) ? dbc_pkg::LEN_W'(1) : held.byte_count;
            busy_o <= 1'b1;
            // The processor is held only for a non-overlapped transfer.
            cpu_stall_o <= !held.overlapped;
            buf_mark <= 1'b0;
            tmr <= dbc_pkg::CNT_W'(dbc_pkg::MEM_CYCLE_CLKS);
            state <= dbc_pkg::ST_SETUP;
          end
        end
        dbc_pkg::ST_SETUP: begin
          // An input transfer waits for the peripheral before its first memory cycle.
          if (tmr_done) begin
            if (cur.output_dir) begin
              mem_req_o <= 1'b1;
              tmr <= dbc_pkg::CNT_W'(dbc_pkg::MEM_CYCLE_CLKS);
              state <= dbc_pkg::ST_READ;
            end else begin
              in_ready_o <= 1'b1;
              state <= dbc_pkg::ST_WAIT_IN;
            end
          end
        end
        dbc_pkg::ST_READ: begin
          if (tmr_done) begin
            // The byte and its mark are latched together at the end of the read cycle.
            buf_mark <= mem_rdata_i.mark;
            out_data_o <= mem_rdata_i.data;
            out_valid_o <= 1'b1;
            state <= dbc_pkg::ST_SEND;
          end
        end
        dbc_pkg::ST_SEND: begin
          // The byte stays offered until the peripheral takes it.
          if (out_ready_i) begin
            out_valid_o <= 1'b0;
            remain <= remain - dbc_pkg::LEN_W'(1);
            mem_addr_o <= next_addr;
            if (last_byte) begin
              state <= dbc_pkg::ST_IDLE;
              busy_o <= 1'b0;
              cpu_stall_o <= 1'b0;
              done_o <= 1'b1;
            end else begin
              mem_req_o <= 1'b1;
              tmr <= dbc_pkg::CNT_W'(dbc_pkg::MEM_CYCLE_CLKS);
              state <= dbc_pkg::ST_READ;
            end
          end
        end
        dbc_pkg::ST_WAIT_IN: begin
          if (in_arrive) begin
            // The byte goes to memory with the write strobe; the mark plane is never written.
            in_ready_o <= 1'b0;
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_wdata_o <= in_data_s2;
            tmr <= dbc_pkg::CNT_W'(dbc_pkg::IN_BYTE_CLKS);
            state <= dbc_pkg::ST_WRITE;
          end
        end
        dbc_pkg::ST_WRITE: begin
          // The old mark is read late in the write cycle, while memory still returns it.
          if (tmr == dbc_pkg::CNT_W'(dbc_pkg::IN_BYTE_CLKS - dbc_pkg::MEM_CYCLE_CLKS + 1)) begin
            buf_mark <= mem_rdata_i.mark;
          end
          if (tmr_done) begin
            remain <= remain - dbc_pkg::LEN_W'(1);
            mem_addr_o <= next_addr;
            if (last_byte) begin
              state <= dbc_pkg::ST_IDLE;
              busy_o <= 1'b0;
              cpu_stall_o <= 1'b0;
              done_o <= 1'b1;
            end else begin
              in_ready_o <= 1'b1;
              state <= dbc_pkg::ST_WAIT_IN;
            end
          end
        end
        default: begin
          state <= dbc_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule : dbc_channel

// *** verilog/dbc_pkg.sv ***
// Package with constants and types for the byte channel.
package dbc_pkg;
  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int LEN_W = 16;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MEM_CYCLE_NS = 980;
  localparam int IN_BYTE_NS = 1330;
  // A least time rounds up to whole cycles.
  localparam int MEM_CYCLE_CLKS = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IN_BYTE_CLKS = (IN_BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic output_dir;
    logic overlapped;
    logic stop_on_mark;
    logic [ADDR_W-1:0] start_addr;
    logic [LEN_W-1:0] byte_count;
  } dbc_cmd_type;

  typedef struct packed {
    logic mark;
    logic [7:0] data;
  } dbc_mem_byte_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_READ = 3'b010,
    ST_SEND = 3'b011,
    ST_WAIT_IN = 3'b100,
    ST_WRITE = 3'b101
  } dbc_state_type;
endpackage : dbc_pkg
